// ===== verilog/sfo_fifo.v
// sample fifo with sticky overflow and partial fill tracking
// assumes writer, reader and buf_clr are driven by logic on mclk, so no synchronisers
//
// Function
// - capacity is exactly 4,194,304 words before full
// - one sample record is 32 words; buffer holds 131,072 records
// - write arriving while full, with no read in the same cycle, sets the overflow flag
// - after overflow all further incoming data is dropped
// - data written before overflow stays intact and readable in order
// - overflow flag stays set until buffer reset, despite reads
// - partial fill flag tracks occupancy and clears when host drains
// - reads return fifo order; read location frees immediately
// - word width is set by the WIDTH parameter, 8 bits by default
`timescale 1ns/10ps
`default_nettype none

`include "sfo_regs.vh"

module sfo_fifo #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // acquisition restart clear
    input wire buf_clr,
    // write side
    input wire wr_valid,
    input wire [WIDTH-1:0] wr_data,
    output wire wr_ready,
    output reg rec_end,
    // read side
    output wire rd_valid,
    output reg [WIDTH-1:0] rd_data,
    input wire rd_ready,
    // status
    output reg overflow_sticky_flag,
    output reg partial_fill_flag,
    output reg [22:0] level
);

////////////////////////////////////////////////////////////////////////////////
// helper functions

// next word address; the address space is exactly the capacity, so it wraps
function [`SFO_ADDR_W-1:0] sfo_ptr_step;
    input [`SFO_ADDR_W-1:0] ptr;
    begin
        sfo_ptr_step = ptr + `SFO_PTR_ONE;
    end
endfunction

// words held: memory count plus the prefetched head word
function [22:0] sfo_occ;
    input [22:0] mem_cnt;
    input head;
    begin
        sfo_occ = mem_cnt + {22'h000000, head};
    end
endfunction

// partial fill threshold test on a word count
function sfo_at_half;
    input [22:0] words;
    begin
        sfo_at_half = (words >= `SFO_HALF);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// storage and pointers

reg [WIDTH-1:0] mem [0:(1<<`SFO_ADDR_W)-1];
reg [`SFO_ADDR_W-1:0] wr_ptr;
reg [`SFO_ADDR_W-1:0] rd_ptr;
reg [`SFO_REC_W-1:0] word_idx;
reg have_data;
reg next_have;

////////////////////////////////////////////////////////////////////////////////
// transfer decisions

// the head word counts toward capacity, so the total never exceeds the depth
wire [22:0] occ = sfo_occ(level, have_data);
wire full = (occ == `SFO_DEPTH);

// a read in the same cycle frees the head, so a write then still fits
wire do_rd = rd_ready && have_data;
wire room = !full || do_rd;

// once the sticky flag is up every word is dropped, even after draining
wire do_wr = wr_valid && room && !overflow_sticky_flag;
wire ovf_hit = wr_valid && !room;

// prefetch register acts as head of queue
wire mem_has = (level != `SFO_CNT_RST);
wire fetch = mem_has && (!have_data || do_rd);

always @* begin
    next_have = have_data;
    if (fetch) begin
        next_have = 1'b1;
    end else if (do_rd) begin
        next_have = 1'b0;
    end
end

assign rd_valid = have_data;
// writer is never stalled; excess words are discarded
assign wr_ready = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// write path and record framing

always @(posedge mclk) begin
    if (do_wr) begin
        mem[wr_ptr] <= wr_data;
    end
end

// rec_end marks the last word of each accepted record
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        wr_ptr <= `SFO_PTR_RST;
        word_idx <= `SFO_IDX_RST;
        rec_end <= 1'b0;
    end else if (buf_clr) begin
        wr_ptr <= `SFO_PTR_RST;
        word_idx <= `SFO_IDX_RST;
        rec_end <= 1'b0;
    end else begin
        rec_end <= 1'b0;
        if (do_wr) begin
            wr_ptr <= sfo_ptr_step(wr_ptr);
            word_idx <= word_idx + `SFO_IDX_ONE;
            rec_end <= (word_idx == `SFO_IDX_LAST);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path

// the head register is refilled in the same edge that the reader takes it
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        rd_ptr <= `SFO_PTR_RST;
        have_data <= 1'b0;
        rd_data <= {WIDTH{1'b0}};
    end else if (buf_clr) begin
        rd_ptr <= `SFO_PTR_RST;
        have_data <= 1'b0;
        rd_data <= {WIDTH{1'b0}};
    end else begin
        have_data <= next_have;
        if (fetch) begin
            rd_data <= mem[rd_ptr];
            rd_ptr <= sfo_ptr_step(rd_ptr);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// occupancy and flags

// level counts memory words only; the head word is added for the flags
wire [22:0] next_level = level + {22'h000000, do_wr} - {22'h000000, fetch};
wire [22:0] next_occ = sfo_occ(next_level, next_have);

// buffer reset wins over a same-cycle overflow event
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        level <= `SFO_CNT_RST;
        overflow_sticky_flag <= 1'b0;
        partial_fill_flag <= 1'b0;
    end else if (buf_clr) begin
        level <= `SFO_CNT_RST;
        overflow_sticky_flag <= 1'b0;
        partial_fill_flag <= 1'b0;
    end else begin
        level <= next_level;
        if (ovf_hit) begin
            overflow_sticky_flag <= 1'b1;
        end
        partial_fill_flag <= sfo_at_half(next_occ);
    end
end

endmodule

`default_nettype wire

// ===== verilog/sfo_regs.vh
// sample fifo constants: capacity, record size, flag thresholds
// assumes inclusion by bare name from the fifo design file
`ifndef SFO_REGS_VH
`define SFO_REGS_VH

`define SFO_ADDR_W 22
`define SFO_DEPTH 23'h400000
`define SFO_HALF 23'h200000
`define SFO_REC_WORDS 6'h20
`define SFO_REC_COUNT 18'h20000
`define SFO_REC_W 5
`define SFO_CNT_RST 23'h000000
`define SFO_PTR_RST 22'h000000
`define SFO_PTR_ONE 22'h000001
`define SFO_IDX_RST 5'h00
`define SFO_IDX_ONE 5'h01
`define SFO_IDX_LAST 5'h1f

`endif

// ===== verif/sfo_chk.sv
// checker on the sample fifo ports
// assumes bind onto sfo_fifo, one clock
`timescale 1ns/10ps
`default_nettype none
module sfo_chk #(parameter WIDTH = 8) (
    input wire logic mclk, rstn, buf_clr, wr_valid, rd_valid, rd_ready,
    input wire logic overflow_sticky_flag, partial_fill_flag,
    input wire logic [WIDTH-1:0] rd_data,
    input wire logic [22:0] level
);
    wire logic ov = overflow_sticky_flag;
    wire logic [22:0] occ = level + {22'h000000, rd_valid};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_push;
        !rd_valid && level == 23'h000000 && wr_valid && !buf_clr && !ov;
    endsequence
    sequence s_full_wr;
        wr_valid && !buf_clr && occ == 23'h400000 && !(rd_valid && rd_ready);
    endsequence
    a_first_word: assert property (s_push ##1 !buf_clr |=> rd_valid)
        else $error("head late");
    a_ovf_stick: assert property (ov && !buf_clr |=> ov)
        else $error("ovf lost");
    a_ovf_set: assert property (s_full_wr |=> ov)
        else $error("ovf not set");
    a_ovf_drop: assert property (ov && !buf_clr |=> level <= $past(level))
        else $error("ovf grew");
    a_clr_all: assert property (buf_clr |=> !ov && !partial_fill_flag && occ == 23'h000000)
        else $error("clr");
    a_half_flag: assert property (partial_fill_flag == (occ >= 23'h200000))
        else $error("pf");
    a_head_hold: assert property (rd_valid && !rd_ready && !buf_clr |=> rd_valid && $stable(rd_data))
        else $error("head moved");
    a_cap_max: assert property (occ <= 23'h400000)
        else $error("level");
endmodule
`default_nettype wire

// ===== verif/sfo_rdr.sv
// host reader model: takes head words with random stalls
// assumes rd_valid/rd_ready handshake on mclk
`timescale 1ns/10ps
`default_nettype none
module sfo_rdr (
    input wire logic mclk, go,
    output logic rd_ready = 1'b0
);
    always @(posedge mclk) rd_ready <= go && ($urandom % 2 == 0);
endmodule
`default_nettype wire

// ===== verif/sfo_fifo_test.sv
// bench: random writes drained by reader model, then stall, clear and reset
// assumes sfo_chk and sfo_rdr compiled alongside; one mclk domain
`timescale 1ns/10ps
`default_nettype none
module sfo_fifo_test;
    localparam int LIMIT = 3000;
    localparam int DEPTH = 4194304;
    localparam int HALF = 2097152;
    logic mclk = 1'b0, rstn = 1'b0, buf_clr = 1'b0, wr_valid = 1'b0, go = 1'b0;
    logic [7:0] wr_data = 8'h00, q[$];
    logic ov_m = 1'b0, rec_m = 1'b0, acc = 1'b0;
    int wcnt = 0;
    wire logic wr_ready, rec_end, rd_valid, rd_ready, overflow_sticky_flag, partial_fill_flag;
    wire logic [7:0] rd_data;
    wire logic [22:0] level;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    always #50 mclk = ~mclk;
    sfo_fifo i_sfo_fifo (.mclk(mclk), .rstn(rstn), .buf_clr(buf_clr), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rec_end(rec_end), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_ready(rd_ready), .overflow_sticky_flag(overflow_sticky_flag),
        .partial_fill_flag(partial_fill_flag), .level(level));
    sfo_rdr i_sfo_rdr (.mclk(mclk), .go(go), .rd_ready(rd_ready));
    task automatic chk(input string s, input logic [22:0] e, input logic [22:0] v);
        cmp_count++;
        if (e !== v) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", s, e, v);
        end
    endtask
    task end_sim;
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // model: queue of accepted words, sticky overflow and record framing
    always @(posedge mclk) begin
        cyc++;
        if (cyc > LIMIT) begin
            error_cnt++;
            end_sim;
        end
        if (!rstn || buf_clr) begin
            q.delete();
            ov_m = 1'b0;
            rec_m = 1'b0;
            wcnt = 0;
        end else begin
            chk("wr_ready", 23'h000001, wr_ready);
            chk("ovf", ov_m, overflow_sticky_flag);
            chk("rec_end", rec_m, rec_end);
            chk("pf", q.size() >= HALF, partial_fill_flag);
            acc = wr_valid && !ov_m && (q.size() < DEPTH || (rd_valid && rd_ready));
            if (rd_valid && rd_ready) chk("rd_data", q.pop_front(), rd_data);
            if (acc) q.push_back(wr_data);
            if (wr_valid && !acc) ov_m = 1'b1;
            rec_m = acc && (wcnt % 32 == 31);
            if (acc) wcnt++;
        end
    end
    initial begin
        void'($urandom(1));
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        go <= 1'b1;
        repeat (300) @(posedge mclk) {wr_valid, wr_data} <= 9'($urandom);
        @(posedge mclk) wr_valid <= 1'b0;
        while (q.size() > 0) @(posedge mclk);
        @(negedge mclk) chk("level", 23'h000000, level);
        @(posedge mclk) go <= 1'b0;
        repeat (40) @(posedge mclk) {wr_valid, wr_data} <= {1'b1, 8'($urandom)};
        @(posedge mclk) wr_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk) begin
            chk("level", 23'(q.size() - 1), level);
            chk("head", 23'h000001, rd_valid);
        end
        @(posedge mclk) buf_clr <= 1'b1;
        @(posedge mclk) buf_clr <= 1'b0;
        @(negedge mclk) begin
            chk("clr level", 23'h000000, level);
            chk("clr head", 23'h000000, rd_valid);
        end
        @(posedge mclk) rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        go <= 1'b1;
        repeat (20) @(posedge mclk) {wr_valid, wr_data} <= {1'b1, 8'($urandom)};
        @(posedge mclk) wr_valid <= 1'b0;
        while (q.size() > 0) @(posedge mclk);
        @(negedge mclk) chk("level", 23'h000000, level);
        end_sim;
    end
endmodule
bind sfo_fifo sfo_chk #(.WIDTH(WIDTH)) i_sfo_chk (.*);
`default_nettype wire
